/* cmcb_bank.sv */
/*
  configuration and status bank of a stackable cell monitor: broadcast
  configuration write over the serial link, flags, results and polling.
  assumes sclk only runs while chip_select_in is low, and that the host
  leaves chip_select_in high for at least 50 ns between frames.
*/
`timescale 1ns/100ps
module cmcb_bank #(
  parameter int POLL_HALF = cmcb_pkg::POLL_HALF_CYC
) (
  // system
  input  wire logic                                    clk,
  input  wire logic                                    srst,
  // serial link
  input  wire logic                                    sclk,
  input  wire logic                                    chip_select_in,
  input  wire logic                                    sdi,
  output logic                                         sdo,
  output logic                                         sdo_oe_n,
  // pins
  input  wire logic                                    monitor_mode_strap,
  input  wire logic                                    gp_pin_one,
  input  wire logic                                    gp_pin_two,
  input  wire logic                                    watchdog_out_pin,
  output logic                                         gp_one_pulldown_on,
  output logic                                         gp_two_pulldown_on,
  output logic [cmcb_pkg::NCELL-1:0]                   discharge_cell_bit,
  // configuration view
  output cmcb_pkg::cmcb_cfg_t                          config_q,
  output logic [7:0]                                   config_byte_zero,
  output logic [2:0]                                   comparator_duty_cycle,
  // measurement side
  input  wire logic                                    conv_busy,
  input  wire logic [cmcb_pkg::NCELL-1:0][cmcb_pkg::CODE_W-1:0] cell_code,
  input  wire logic [1:0][cmcb_pkg::CODE_W-1:0]        ext_temp_code,
  input  wire logic [cmcb_pkg::CODE_W-1:0]             int_temp_code,
  input  wire logic                                    thermal_event,
  input  wire logic                                    temp_group_read,
  input  wire logic                                    poll_start,
  // status
  output logic [cmcb_pkg::NCELL-1:0][cmcb_pkg::CODE_W-1:0] cell_result,
  output cmcb_pkg::cmcb_flags_t                        cell_flags,
  output logic [1:0][cmcb_pkg::CODE_W-1:0]             ext_temp_result,
  output logic [cmcb_pkg::CODE_W-1:0]                  int_temp_result,
  output logic                                         thermal_trip_flag,
  output logic                                         upper_cells_blocked
);
  localparam int PCW = $clog2(POLL_HALF + 1);

  if (POLL_HALF < 2) begin : g_poll_half_check
    $error("POLL_HALF must be at least 2");
  end

  function automatic logic [cmcb_pkg::CODE_W-1:0] thr(input logic [7:0] f);
    thr = {f, 4'h0};
  endfunction

  function automatic cmcb_pkg::cmcb_cfg_t to_cfg(input logic [7:0] b [cmcb_pkg::CFG_BYTES]);
    cmcb_pkg::cmcb_cfg_t c;
    c.cdc        = b[0][cmcb_pkg::B0_CDC_LSB +: 3];
    c.ten_cell   = b[0][cmcb_pkg::B0_TEN];
    c.level_poll = b[0][cmcb_pkg::B0_LEVEL];
    c.gp_one     = b[0][cmcb_pkg::B0_GP_ONE];
    c.gp_two     = b[0][cmcb_pkg::B0_GP_TWO];
    c.wdog       = b[0][cmcb_pkg::B0_WDOG];
    c.dcc        = {b[2][3:0], b[1]};
    c.mask       = {b[3], b[2][7:4]};
    c.undervolt_threshold        = b[4];
    c.overvolt_threshold        = b[5];
    to_cfg = c;
  endfunction

  // ==========================================================
  // link domain receiver
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [2:0] byte_cnt;
  logic [2:0] next_byte_cnt;
  logic [6:0] shreg;
  logic [6:0] next_shreg;
  logic       cmd_ok;
  logic       next_cmd_ok;
  logic       complete;
  logic       next_complete;
  logic [7:0] rx_buf [cmcb_pkg::CFG_BYTES];
  logic [7:0] next_rx_buf [cmcb_pkg::CFG_BYTES];
  logic [7:0] rx_byte;

  always_comb begin
    rx_byte       = {shreg, sdi};
    next_bit_cnt  = bit_cnt + 3'h1;
    next_byte_cnt = byte_cnt;
    next_shreg    = rx_byte[6:0];
    next_cmd_ok   = cmd_ok;
    next_complete = complete;
    next_rx_buf   = rx_buf;
    if (bit_cnt == 3'h0 && byte_cnt == 3'h0) begin
      next_complete = 1'b0;
    end
    if (bit_cnt == 3'h7) begin
      if (byte_cnt == 3'h0) begin
        next_cmd_ok   = (rx_byte == cmcb_pkg::WRITE_CONFIG_CMD);
        next_byte_cnt = 3'h1;
      end else if (byte_cnt <= 3'(cmcb_pkg::CFG_BYTES)) begin
        if (cmd_ok) begin
          next_rx_buf[byte_cnt - 3'h1] = rx_byte;
          next_complete = (byte_cnt == 3'(cmcb_pkg::CFG_BYTES));
        end
        next_byte_cnt = byte_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge sclk or posedge chip_select_in) begin
    if (chip_select_in) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      cmd_ok   <= 1'b0;
    end else begin
      bit_cnt  <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      cmd_ok   <= next_cmd_ok;
    end
  end

  always_ff @(posedge sclk) begin
    shreg    <= next_shreg;
    complete <= next_complete;
    rx_buf   <= next_rx_buf;
  end

  // ==========================================================
  // crossings and pin sampling
  logic                     cs_meta;
  logic                     cs_sync;
  logic                     cs_prev;
  logic                     done_meta;
  logic                     done_sync;
  logic [cmcb_pkg::NPIN-1:0] pin_meta;
  logic [cmcb_pkg::NPIN-1:0] pin_sync;
  logic                     cs_rise;

  always_ff @(posedge clk) begin
    cs_meta   <= chip_select_in;
    cs_sync   <= cs_meta;
    cs_prev   <= cs_sync;
    done_meta <= complete;
    done_sync <= done_meta;
    pin_meta  <= {monitor_mode_strap, watchdog_out_pin, gp_pin_two, gp_pin_one};
    pin_sync  <= pin_meta;
  end

  assign cs_rise = cs_sync & ~cs_prev;

  // ==========================================================
  // configuration and pin control
  cmcb_pkg::cmcb_cfg_t next_config;
  logic [7:0]          next_byte_zero;
  logic [2:0]          next_cdc;
  logic                strap_low;

  always_comb begin
    strap_low   = ~pin_sync[cmcb_pkg::PIN_STRAP];
    next_config = config_q;
    if (cs_rise && done_sync) begin
      next_config = to_cfg(rx_buf);
    end
    next_cdc = strap_low ? cmcb_pkg::CDC_STRAP : next_config.cdc;
    next_byte_zero = {pin_sync[cmcb_pkg::PIN_WDOG],
                      pin_sync[cmcb_pkg::PIN_GP_TWO],
                      pin_sync[cmcb_pkg::PIN_GP_ONE],
                      next_config.level_poll, next_config.ten_cell, next_cdc};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      config_q              <= cmcb_pkg::CFG_RESET;
      config_byte_zero      <= 8'h00;
      comparator_duty_cycle <= cmcb_pkg::CFG_RESET.cdc;
      gp_one_pulldown_on    <= 1'b0;
      gp_two_pulldown_on    <= 1'b0;
      discharge_cell_bit    <= '0;
    end else begin
      config_q              <= next_config;
      config_byte_zero      <= next_byte_zero;
      comparator_duty_cycle <= next_cdc;
      gp_one_pulldown_on    <= ~next_config.gp_one;
      gp_two_pulldown_on    <= ~next_config.gp_two;
      discharge_cell_bit    <= next_config.dcc;
    end
  end

  // ==========================================================
  // results, flags and temperatures
  logic [cmcb_pkg::NCELL-1:0][cmcb_pkg::CODE_W-1:0] next_result;
  cmcb_pkg::cmcb_flags_t                            next_flags;
  logic [cmcb_pkg::CODE_W-1:0]                      uv_th;
  logic [cmcb_pkg::CODE_W-1:0]                      ov_th;
  logic                                             blocked;
  logic                                             next_thermal;

  always_comb begin
    uv_th = strap_low ? cmcb_pkg::FACTORY_UV : thr(config_q.undervolt_threshold);
    ov_th = strap_low ? cmcb_pkg::FACTORY_OV : thr(config_q.overvolt_threshold);
    next_flags = cell_flags;
    for (int i = 0; i < cmcb_pkg::NCELL; i++) begin
      blocked = config_q.ten_cell && (i >= cmcb_pkg::UPPER_CELL_FIRST);
      if (conv_busy) begin
        next_result[i] = cmcb_pkg::RESULT_BUSY;
      end else if (blocked) begin
        next_result[i] = cmcb_pkg::RESULT_BLOCKED;
      end else begin
        next_result[i] = cell_code[i];
      end
      if (!conv_busy) begin
        next_flags.under[i] = (cell_code[i] < uv_th);
        next_flags.over[i]  = (cell_code[i] > ov_th);
      end
      if (config_q.mask[i] || blocked) begin
        next_flags.under[i] = 1'b0;
        next_flags.over[i]  = 1'b0;
      end
    end
    next_thermal = thermal_event | (thermal_trip_flag & ~temp_group_read);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cell_result         <= '0;
      cell_flags          <= '0;
      ext_temp_result     <= '0;
      int_temp_result     <= '0;
      thermal_trip_flag   <= 1'b0;
      upper_cells_blocked <= 1'b0;
    end else begin
      cell_result         <= next_result;
      cell_flags          <= next_flags;
      ext_temp_result     <= ext_temp_code;
      int_temp_result     <= int_temp_code;
      thermal_trip_flag   <= next_thermal;
      upper_cells_blocked <= config_q.ten_cell;
    end
  end

  // ==========================================================
  // conversion status (toggle) and flag status (level) polling on the serial output
  typedef enum logic [3:0] {
    POLL_IDLE  = 4'b0001,
    POLL_BUSY  = 4'b0010,
    POLL_TOG   = 4'b0100,
    POLL_LEVEL = 4'b1000
  } cmcb_poll_t;

  cmcb_poll_t     poll_st;
  cmcb_poll_t     next_poll_st;
  logic [PCW-1:0] poll_cnt;
  logic [PCW-1:0] next_poll_cnt;
  logic           next_sdo;
  logic           next_sdo_oe_n;

  always_comb begin
    next_poll_st  = poll_st;
    next_poll_cnt = poll_cnt;
    next_sdo      = sdo;
    next_sdo_oe_n = 1'b0;
    unique case (poll_st)
      POLL_IDLE: begin
        next_sdo      = 1'b1;
        next_sdo_oe_n = 1'b1;
        if (poll_start && !cs_sync) begin
          next_poll_st = config_q.level_poll ? POLL_LEVEL : POLL_BUSY;
        end
      end
      POLL_BUSY: begin
        next_sdo      = 1'b0;
        next_poll_cnt = '0;
        if (!conv_busy) begin
          next_poll_st = POLL_TOG;
        end
      end
      POLL_TOG: begin
        if (poll_cnt == PCW'(POLL_HALF - 1)) begin
          next_poll_cnt = '0;
          next_sdo      = ~sdo;
        end else begin
          next_poll_cnt = poll_cnt + PCW'(1);
        end
      end
      POLL_LEVEL: begin
        next_sdo = ~(|cell_flags.under | |cell_flags.over);
      end
    endcase
    if (cs_sync && poll_st != POLL_IDLE) begin
      next_poll_st  = POLL_IDLE;
      next_sdo      = 1'b1;
      next_sdo_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      poll_st  <= POLL_IDLE;
      poll_cnt <= '0;
      sdo      <= 1'b1;
      sdo_oe_n <= 1'b1;
    end else begin
      poll_st  <= next_poll_st;
      poll_cnt <= next_poll_cnt;
      sdo      <= next_sdo;
      sdo_oe_n <= next_sdo_oe_n;
    end
  end
endmodule

/* cmcb_pkg.sv */
/*
  constants, configuration layout and carrier types of the cell monitor
  configuration and status bank.
  assumes nothing beyond a systemverilog compiler.
*/
package cmcb_pkg;
  // ==========================================================
  // sizes
  localparam int NCELL     = 12;
  localparam int CODE_W    = 12;
  localparam int CFG_BYTES = 6;
  localparam int NPIN      = 4;
  localparam int THR_SHIFT = 4;
  localparam int UPPER_CELL_FIRST = 10;
  // ==========================================================
  // codes
  localparam logic [7:0]        WRITE_CONFIG_CMD = 8'h01;
  localparam logic [2:0]        CDC_STRAP        = 3'h5;
  localparam logic [CODE_W-1:0] RESULT_BUSY      = 12'hfff;
  localparam logic [CODE_W-1:0] RESULT_BLOCKED   = 12'h000;
  localparam logic [CODE_W-1:0] FACTORY_UV       = 12'h400;
  localparam logic [CODE_W-1:0] FACTORY_OV       = 12'h9c0;
  // ==========================================================
  // pin vector positions
  localparam int PIN_GP_ONE = 0;
  localparam int PIN_GP_TWO = 1;
  localparam int PIN_WDOG   = 2;
  localparam int PIN_STRAP  = 3;
  // ==========================================================
  // byte zero field positions
  localparam int B0_CDC_LSB  = 0;
  localparam int B0_TEN      = 3;
  localparam int B0_LEVEL    = 4;
  localparam int B0_GP_ONE   = 5;
  localparam int B0_GP_TWO   = 6;
  localparam int B0_WDOG     = 7;
  // ==========================================================
  // timing
  localparam int CLK_NS       = 10;
  localparam int POLL_HALF_NS = 500000;
  localparam int POLL_HALF_CYC = POLL_HALF_NS / CLK_NS;
  // ==========================================================
  // types
  typedef struct packed {
    logic [7:0]       overvolt_threshold;
    logic [7:0]       undervolt_threshold;
    logic [NCELL-1:0] mask;
    logic [NCELL-1:0] dcc;
    logic             wdog;
    logic             gp_two;
    logic             gp_one;
    logic             level_poll;
    logic             ten_cell;
    logic [2:0]       cdc;
  } cmcb_cfg_t;

  typedef struct packed {
    logic [NCELL-1:0] under;
    logic [NCELL-1:0] over;
  } cmcb_flags_t;

  localparam cmcb_cfg_t CFG_RESET = '{overvolt_threshold: 8'h00, undervolt_threshold: 8'h00, mask: 12'h000, dcc: 12'h000,
                                      wdog: 1'b0, gp_two: 1'b1, gp_one: 1'b1, level_poll: 1'b0,
                                      ten_cell: 1'b0, cdc: 3'h0};
endpackage

/* cmcb_properties.sv */
/*
  port assertions of the cell monitor bank.
  assumes a bind from the testbench top file.
*/
`timescale 1ns/100ps
module cmcb_properties #(
  parameter int POLL_HALF = 4
) (
  // system
  input wire logic                  clk,
  input wire logic                  srst,
  // link and pins
  input wire logic                  chip_select_in,
  input wire logic                  sdo,
  input wire logic                  sdo_oe_n,
  input wire logic                  monitor_mode_strap,
  input wire logic                  gp_pin_one,
  // measurement side
  input wire logic                  conv_busy,
  input wire logic [11:0]           int_temp_code,
  input wire logic                  thermal_event,
  input wire logic                  temp_group_read,
  input wire logic                  poll_start,
  // outputs
  input wire logic                  gp_one_pulldown_on,
  input wire logic [11:0]           discharge_cell_bit,
  input wire cmcb_pkg::cmcb_cfg_t   config_q,
  input wire logic [7:0]            config_byte_zero,
  input wire logic [2:0]            comparator_duty_cycle,
  input wire logic [11:0][11:0]     cell_result,
  input wire cmcb_pkg::cmcb_flags_t cell_flags,
  input wire logic [11:0]           int_temp_result,
  input wire logic                  thermal_trip_flag,
  input wire logic                  upper_cells_blocked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // properties
  property p_strap; (!monitor_mode_strap)[*4] |-> comparator_duty_cycle == cmcb_pkg::CDC_STRAP; endproperty
  property p_ten;
    config_q.ten_cell[*2] |-> upper_cells_blocked && cell_flags.under[11:10] == 2'h0 && cell_flags.over[11:10] == 2'h0;
  endproperty
  property p_poll;
    (!chip_select_in)[*3] ##0 (poll_start && sdo_oe_n && !config_q.level_poll) |-> ##2 !sdo && !sdo_oe_n;
  endproperty
  property p_pull; $stable(config_q.gp_one) |-> gp_one_pulldown_on == !config_q.gp_one; endproperty
  property p_pin; $stable(gp_pin_one)[*4] |-> config_byte_zero[cmcb_pkg::B0_GP_ONE] == gp_pin_one; endproperty
  property p_dcc; $stable(config_q.dcc) |-> discharge_cell_bit == config_q.dcc; endproperty
  property p_busy; conv_busy[*2] |-> cell_result[0] == cmcb_pkg::RESULT_BUSY; endproperty
  property p_temp; !$past(srst) |-> int_temp_result == $past(int_temp_code); endproperty
  property p_trip_set; thermal_event |=> thermal_trip_flag; endproperty
  property p_trip_clr; temp_group_read && !thermal_event |=> !thermal_trip_flag; endproperty
  property p_latch; !$stable(config_q) |-> chip_select_in && $past(chip_select_in, 3); endproperty
  // ==========================================================
  // assertions
  a_strap: assert property (p_strap) else $error("duty cycle not forced");
  a_ten: assert property (p_ten) else $error("upper cells not blocked");
  a_poll: assert property (p_poll) else $error("poll output not low");
  a_pull: assert property (p_pull) else $error("pulldown wrong");
  a_pin: assert property (p_pin) else $error("pin readback wrong");
  a_dcc: assert property (p_dcc) else $error("discharge wrong");
  a_busy: assert property (p_busy) else $error("busy result wrong");
  a_temp: assert property (p_temp) else $error("temperature copy wrong");
  a_trip_set: assert property (p_trip_set) else $error("thermal flag not set");
  a_trip_clr: assert property (p_trip_clr) else $error("thermal flag not cleared");
  a_latch: assert property (p_latch) else $error("config changed off frame end");
  cover property (!sdo_oe_n && !conv_busy && $changed(sdo));
  cover property (!$stable(config_q));
  cover property ($rose(thermal_trip_flag));
endmodule

/* cmcb_host.sv */
/*
  host model of the serial link: broadcast configuration frames, select.
  assumes the bank samples sdi on rising sclk.
*/
`timescale 1ns/100ps
module cmcb_host (
  // serial link
  output logic sclk,
  output logic chip_select_in,
  output logic sdi
);
  localparam realtime HALF = 62.5;
  initial begin
    sclk = 1'b0;
    chip_select_in = 1'b1;
    sdi = 1'b0;
  end
  // ==========================================================
  // frame: select, command, n data bytes msb first, release
  task automatic frame(input logic [7:0] cmd, input cmcb_pkg::cmcb_cfg_t c, input int n);
    logic [6:0][7:0] b;
    b = {cmd, c.wdog, c.gp_two, c.gp_one, c.level_poll, c.ten_cell, c.cdc, c.dcc[7:0],
         c.mask[3:0], c.dcc[11:8], c.mask[11:4], c.undervolt_threshold, c.overvolt_threshold};
    #3.3 chip_select_in = 1'b0;
    #HALF;
    for (int k = 0; k <= n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        sdi = b[6-k][i];
        #HALF sclk = 1'b1;
        #HALF sclk = 1'b0;
      end
    end
    sdi = ~sdi;
    #HALF chip_select_in = 1'b1;
    #100;
  endtask
  // ==========================================================
  // plain select, used to hold and end polling
  task automatic select(input logic v);
    #3.3 chip_select_in = v;
    #HALF;
  endtask
endmodule

/* testbench.sv */
/*
  self-checking bench of the cell monitor bank.
  assumes cmcb_pkg, cmcb_host and cmcb_properties are compiled first.
*/
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sclk, chip_select_in, sdi, sdo, sdo_oe_n, gp_one_pulldown_on, gp_two_pulldown_on;
  logic monitor_mode_strap, gp_pin_one, gp_pin_two, watchdog_out_pin, upper_cells_blocked;
  logic conv_busy, thermal_event, temp_group_read, poll_start, thermal_trip_flag;
  logic [11:0]       discharge_cell_bit, int_temp_code, int_temp_result;
  logic [7:0]        config_byte_zero;
  logic [2:0]        comparator_duty_cycle;
  logic [11:0][11:0] cell_code, cell_result;
  logic [1:0][11:0]  ext_temp_code, ext_temp_result;
  cmcb_pkg::cmcb_cfg_t   config_q, cfg_a, cfg_b, exp_q[$];
  cmcb_pkg::cmcb_cfg_t   last_cfg = cmcb_pkg::CFG_RESET;
  cmcb_pkg::cmcb_flags_t cell_flags;
  int fails = 0;
  int n_compared = 0;
  int t;
  always #5 clk = ~clk;
  cmcb_host host (.sclk, .chip_select_in, .sdi);
  cmcb_bank #(.POLL_HALF(4)) DUT (.clk, .srst, .sclk, .chip_select_in, .sdi, .sdo, .sdo_oe_n,
    .monitor_mode_strap, .gp_pin_one, .gp_pin_two, .watchdog_out_pin, .gp_one_pulldown_on,
    .gp_two_pulldown_on, .discharge_cell_bit, .config_q, .config_byte_zero, .comparator_duty_cycle,
    .conv_busy, .cell_code, .ext_temp_code, .int_temp_code, .thermal_event, .temp_group_read,
    .poll_start, .cell_result, .cell_flags, .ext_temp_result, .int_temp_result, .thermal_trip_flag,
    .upper_cells_blocked);
  // ==========================================================
  // helpers
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic done(input string s);
    $display("test done: %s", s);
  endtask
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic cmcb_pkg::cmcb_cfg_t rand_cfg();
    cmcb_pkg::cmcb_cfg_t c;
    c = 48'({$urandom, $urandom});
    c.ten_cell = 1'b0;
    c.level_poll = 1'b0;
    return c;
  endfunction
  task automatic write_cfg(input cmcb_pkg::cmcb_cfg_t c);
    exp_q.push_back(c);
    host.frame(cmcb_pkg::WRITE_CONFIG_CMD, c, 6);
    tick(8);
    check(exp_q.size(), 0);
  endtask
  // ==========================================================
  // configuration monitor
  always @(posedge clk) begin
    if (!srst && config_q !== last_cfg) begin
      if (exp_q.size() == 0)
        check(config_q, last_cfg);
      else
        check(config_q, exp_q.pop_front());
    end
    last_cfg <= config_q;
  end
  // ==========================================================
  // watchdog
  initial begin
    #300000;
    fails++;
    final_report();
  end
  // ==========================================================
  // tests
  initial begin
    {monitor_mode_strap, gp_pin_one, gp_pin_two, watchdog_out_pin} = 4'hf;
    {conv_busy, thermal_event, temp_group_read, poll_start} = 4'h0;
    cell_code = '0;
    ext_temp_code = '0;
    int_temp_code = '0;
    void'($urandom(32'h0f05));
    tick(12);
    srst <= 1'b0;
    tick(3);
    cfg_a = rand_cfg();
    write_cfg(cfg_a);
    check(gp_one_pulldown_on, !cfg_a.gp_one);
    check(gp_two_pulldown_on, !cfg_a.gp_two);
    check(discharge_cell_bit, cfg_a.dcc);
    check(comparator_duty_cycle, cfg_a.cdc);
    check(config_byte_zero[4:0], {cfg_a.level_poll, cfg_a.ten_cell, cfg_a.cdc});
    done("configuration write");
    host.frame(cmcb_pkg::WRITE_CONFIG_CMD, rand_cfg(), 5);
    host.frame(8'h02, rand_cfg(), 6);
    tick(8);
    check(config_q, cfg_a);
    done("refused frames");
    cfg_b = cfg_a;
    cfg_b.undervolt_threshold = 8'h40;
    cfg_b.overvolt_threshold = 8'h80;
    cfg_b.mask = 12'h008;
    write_cfg(cfg_b);
    for (int i = 0; i < 12; i++)
      cell_code[i] <= (i == 0) ? 12'h3ff : (i == 1) ? 12'h801 : (i == 3) ? 12'h100 : 12'h600;
    tick(4);
    check(cell_flags, {12'h001, 12'h002});
    monitor_mode_strap <= 1'b0;
    tick(5);
    check(comparator_duty_cycle, cmcb_pkg::CDC_STRAP);
    check(cell_flags, {12'h001, 12'h000});
    check(config_byte_zero[2:0], cmcb_pkg::CDC_STRAP);
    monitor_mode_strap <= 1'b1;
    done("thresholds and flags");
    conv_busy <= 1'b1;
    tick(3);
    check(cell_result[0], cmcb_pkg::RESULT_BUSY);
    for (int i = 0; i < 12; i++)
      cell_code[i] <= 12'($urandom);
    ext_temp_code <= 24'($urandom);
    int_temp_code <= 12'($urandom);
    conv_busy <= 1'b0;
    tick(3);
    for (int i = 0; i < 12; i++)
      check(cell_result[i], cell_code[i]);
    check(ext_temp_result, ext_temp_code);
    check(int_temp_result, int_temp_code);
    done("results");
    for (int r = 0; r < 3; r++) begin
      {gp_pin_one, gp_pin_two, watchdog_out_pin} <= 3'($urandom);
      tick(5);
      check(config_byte_zero[7:5], {watchdog_out_pin, gp_pin_two, gp_pin_one});
    end
    done("pin readback");
    cfg_b.ten_cell = 1'b1;
    write_cfg(cfg_b);
    cell_code[10] <= 12'h100;
    tick(4);
    check(upper_cells_blocked, 1'b1);
    check(cell_result[10], cmcb_pkg::RESULT_BLOCKED);
    check(cell_flags.under[11:10], 2'h0);
    done("ten cell mode");
    thermal_event <= 1'b1;
    tick(1);
    thermal_event <= 1'b0;
    tick(2);
    check(thermal_trip_flag, 1'b1);
    {thermal_event, temp_group_read} <= 2'b11;
    tick(1);
    {thermal_event, temp_group_read} <= 2'b00;
    tick(2);
    check(thermal_trip_flag, 1'b1);
    temp_group_read <= 1'b1;
    tick(1);
    temp_group_read <= 1'b0;
    tick(2);
    check(thermal_trip_flag, 1'b0);
    done("thermal flag");
    host.select(1'b0);
    tick(4);
    poll_start <= 1'b1;
    conv_busy <= 1'b1;
    tick(1);
    poll_start <= 1'b0;
    tick(8);
    check({sdo, sdo_oe_n}, 2'b00);
    conv_busy <= 1'b0;
    tick(2);
    for (t = 0; t < 20 && sdo === 1'b0; t++)
      tick(1);
    for (t = 0; t < 20 && sdo === 1'b1; t++)
      tick(1);
    check(t, 4);
    host.select(1'b1);
    tick(5);
    check({sdo, sdo_oe_n}, 2'b11);
    done("toggle polling");
    cfg_b.level_poll = 1'b1;
    write_cfg(cfg_b);
    for (int i = 0; i < 12; i++)
      cell_code[i] <= 12'h600;
    host.select(1'b0);
    tick(4);
    poll_start <= 1'b1;
    tick(1);
    poll_start <= 1'b0;
    tick(3);
    check({sdo, sdo_oe_n}, 2'b10);
    cell_code[0] <= 12'h3ff;
    tick(3);
    check({sdo, sdo_oe_n}, 2'b00);
    host.select(1'b1);
    tick(5);
    check({sdo, sdo_oe_n}, 2'b11);
    done("level polling");
    final_report();
  end
endmodule

bind cmcb_bank cmcb_properties #(.POLL_HALF(POLL_HALF)) u_props (.clk, .srst, .chip_select_in, .sdo, .sdo_oe_n,
  .monitor_mode_strap, .gp_pin_one, .conv_busy, .int_temp_code, .thermal_event, .temp_group_read, .poll_start,
  .gp_one_pulldown_on, .discharge_cell_bit, .config_q, .config_byte_zero, .comparator_duty_cycle, .cell_result,
  .cell_flags, .int_temp_result, .thermal_trip_flag, .upper_cells_blocked);
